// [rtl/pmds_data_stretch.sv]
// Page-mode external data access sequencer with stretch control
// Functional notes
// - Each stretch cycle is four system clocks
// - Codes 0-3 give 0-3, 4-7 give 7-10
// - Code 0: no stretch, two basic cycles
// - Codes 1-3 add that many stretch cycles
// - First stretch: one clock setup, one hold
// - Codes 4-7: two cycles setup, one hold
// - Large group page miss widens address latch strobe
// - Page hit cycle shorter than page miss in 2- and 4-clock page modes
// - Alternate page bus matches nonpage data timing
// - Narrow pages strobe 1,3,7..27 clocks
// - Wide pages strobe 2,4,8..28 clocks
// - Oscillator width scales with clock setting
// - Page mode only while page enable set
// - Stretch select resets to one
`include "pmds_defs.svh"
module pmds_data_stretch import pmds_pkg::*; #(
  parameter int LEN_W = 6
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // Configuration
  input wire logic stretch_wr,
  input wire logic [2:0] stretch_wdata,
  input wire logic page_bus_enable,
  input wire logic [1:0] page_cycle_select,
  input wire logic [1:0] clock_divide_select,
  input wire logic clock_multiplier_select,
  // Access request
  input wire logic access_req,
  input wire logic access_write,
  input wire logic page_hit,
  // Status
  output logic [2:0] stretch_select,
  output logic [3:0] stretch_cycles,
  output logic [16:0] strobe_width_qosc,
  output logic busy,
  output logic access_done,
  // External bus strobes
  output logic ale,
  output logic rd_n,
  output logic wr_n
);
  if (LEN_W != 6) begin : g_chk
    $error("pmds_data_stretch: LEN_W must match pmds_len_t");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  pmds_phase_e state_ff;
  pmds_phase_e nxt_state;
  pmds_phase_e first_ph;
  pmds_phase_e follow_ph;
  logic [2:0] stretch_sel_ff;
  logic [2:0] nxt_stretch_sel;
  logic write_ff;
  logic nxt_write;
  logic ale_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic done_ff;
  logic [3:0] cycles_ff;
  logic [16:0] qosc_ff;
  pmds_len_t ale_len_ff;
  pmds_len_t setup_len_ff;
  pmds_len_t strobe_len_ff;
  pmds_len_t hold_len_ff;
  pmds_len_t tail_len_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic idle;
  logic take;
  logic adv;
  logic cnt_last;
  logic cnt_load;
  logic miss_eff;
  logic [12:0] qosc_scale;
  logic [2:0] clk_set;
  logic [3:0] live_cycles;
  logic [6:0] live_hit_total;
  logic [6:0] live_miss_total;
  pmds_len_t live_ale;
  pmds_len_t live_setup;
  pmds_len_t live_strobe;
  pmds_len_t live_hold;
  pmds_len_t live_tail;
  pmds_len_t sel_ale;
  pmds_len_t sel_setup;
  pmds_len_t sel_strobe;
  pmds_len_t sel_hold;
  pmds_len_t sel_tail;
  pmds_len_t load_len;

  assign idle = (state_ff == PH_IDLE);
  assign take = idle && access_req;
  assign adv = !idle && cnt_last;
  assign nxt_stretch_sel = stretch_wr ? stretch_wdata : stretch_sel_ff;
  // One-clock page mode and the fixed four-clock buses always re-latch the address
  assign miss_eff = !page_hit || !page_bus_enable ||
                    (page_cycle_select == `PMDS_PAGES_ALT) ||
                    (page_cycle_select == `PMDS_PAGES_1CLK);
  assign nxt_write = idle ? access_write : write_ff;

  pmds_timing u_timing (
    .stretch_code(stretch_sel_ff),
    .page_cycle_select(page_cycle_select),
    .page_bus_enable(page_bus_enable),
    .miss(miss_eff),
    .stretch_cycles(live_cycles),
    .ale_len(live_ale),
    .setup_len(live_setup),
    .strobe_len(live_strobe),
    .hold_len(live_hold),
    .tail_len(live_tail),
    .hit_total(live_hit_total),
    .miss_total(live_miss_total)
  );

  // Lengths are frozen for the whole access, so a mid-access write is safe
  assign sel_ale = idle ? live_ale : ale_len_ff;
  assign sel_setup = idle ? live_setup : setup_len_ff;
  assign sel_strobe = idle ? live_strobe : strobe_len_ff;
  assign sel_hold = idle ? live_hold : hold_len_ff;
  assign sel_tail = idle ? live_tail : tail_len_ff;

  assign first_ph = (sel_ale != 6'h00) ? PH_ALE :
                    (sel_setup != 6'h00) ? PH_SETUP : PH_STROBE;

  always_comb begin
    case (state_ff)
      PH_ALE: follow_ph = (sel_setup != 6'h00) ? PH_SETUP : PH_STROBE;
      PH_SETUP: follow_ph = PH_STROBE;
      PH_STROBE: follow_ph = (sel_hold != 6'h00) ? PH_HOLD :
                             (sel_tail != 6'h00) ? PH_TAIL : PH_IDLE;
      PH_HOLD: follow_ph = (sel_tail != 6'h00) ? PH_TAIL : PH_IDLE;
      default: follow_ph = PH_IDLE;
    endcase
  end

  assign nxt_state = idle ? (access_req ? first_ph : PH_IDLE) : (adv ? follow_ph : state_ff);
  assign cnt_load = take || adv;

  always_comb begin
    case (nxt_state)
      PH_ALE: load_len = sel_ale;
      PH_SETUP: load_len = sel_setup;
      PH_STROBE: load_len = sel_strobe;
      PH_HOLD: load_len = sel_hold;
      PH_TAIL: load_len = sel_tail;
      default: load_len = 6'h00;
    endcase
  end

  pmds_phase_cnt #(
    .LEN_W(LEN_W)
  ) u_cnt (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .load(cnt_load),
    .load_val(load_len),
    .last(cnt_last)
  );

  // Quarter oscillator clocks per system clock
  assign clk_set = {clock_multiplier_select, clock_divide_select};
  assign qosc_scale = (clock_divide_select == `PMDS_CD_SLOW) ? `PMDS_SCALE_SLOW :
                      (clk_set == `PMDS_CLK_QUARTER) ? `PMDS_SCALE_QUARTER :
                      (clk_set == `PMDS_CLK_HALF) ? `PMDS_SCALE_HALF : `PMDS_SCALE_DIV1;

  ////////////////////////////////////////////////////////////////////////////
  // State

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= PH_IDLE;
      stretch_sel_ff <= `PMDS_STRETCH_RST;
      write_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      stretch_sel_ff <= nxt_stretch_sel;
      write_ff <= nxt_write;
      done_ff <= adv && (follow_ph == PH_IDLE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ale_len_ff <= 6'h00;
      setup_len_ff <= 6'h00;
      strobe_len_ff <= 6'h00;
      hold_len_ff <= 6'h00;
      tail_len_ff <= 6'h00;
    end else if (ce && take) begin
      ale_len_ff <= live_ale;
      setup_len_ff <= live_setup;
      strobe_len_ff <= live_strobe;
      hold_len_ff <= live_hold;
      tail_len_ff <= live_tail;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cycles_ff <= 4'h1;
      qosc_ff <= 17'h0_0000;
    end else if (ce) begin
      cycles_ff <= live_cycles;
      qosc_ff <= 17'(live_strobe) * 17'(qosc_scale);
    end
  end

  // Strobes only in the strobe phase, never in setup or hold
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
    end else if (ce) begin
      ale_ff <= (nxt_state == PH_ALE);
      rd_n_ff <= !((nxt_state == PH_STROBE) && !nxt_write);
      wr_n_ff <= !((nxt_state == PH_STROBE) && nxt_write);
    end
  end

  assign stretch_select = stretch_sel_ff;
  assign stretch_cycles = cycles_ff;
  assign strobe_width_qosc = qosc_ff;
  assign busy = !idle;
  assign access_done = done_ff;
  assign ale = ale_ff;
  assign rd_n = rd_n_ff;
  assign wr_n = wr_n_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic strobe_on;
  logic [5:0] chk_strobe_cnt_ff;
  logic [6:0] chk_acc_cnt_ff;
  logic [2:0] chk_code_ff;
  logic chk_wide_ff;
  logic chk_miss_ff;
  logic chk_large_ff;
  logic [5:0] chk_exp_w;
  logic [5:0] chk_add_w;

  assign strobe_on = !rd_n_ff || !wr_n_ff;
  // Independent table form: 4*code-2 extra clocks once stretched
  assign chk_add_w = (chk_code_ff == 3'h0) ? 6'h00 : 6'({chk_code_ff, 2'b00} - 5'h02);
  assign chk_exp_w = (chk_wide_ff ? 6'h02 : 6'h01) + chk_add_w;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chk_strobe_cnt_ff <= 6'h00;
      chk_acc_cnt_ff <= 7'h00;
      chk_code_ff <= 3'h0;
      chk_wide_ff <= 1'b0;
      chk_miss_ff <= 1'b0;
      chk_large_ff <= 1'b0;
    end else if (ce) begin
      if (take) begin
        chk_strobe_cnt_ff <= 6'h00;
        chk_acc_cnt_ff <= 7'h01;
        chk_code_ff <= stretch_sel_ff;
        chk_wide_ff <= !page_bus_enable || page_cycle_select[1];
        chk_miss_ff <= miss_eff;
        chk_large_ff <= stretch_sel_ff[2];
      end else begin
        if (strobe_on) begin
          chk_strobe_cnt_ff <= chk_strobe_cnt_ff + 6'h01;
        end
        if (!idle) begin
          chk_acc_cnt_ff <= chk_acc_cnt_ff + 7'h01;
        end
      end
    end
  end

  a_reset_stretch_one: assert property (@(posedge clk_sys) reset |=> stretch_sel_ff == 3'h1)
    else $error("stretch select not one after reset");

  a_stretch_code_map: assert property (@(posedge clk_sys) disable iff (reset)
    live_cycles == (stretch_sel_ff[2] ? {1'b0, stretch_sel_ff} + 4'h3 : {1'b0, stretch_sel_ff}))
    else $error("stretch cycle mapping wrong");

  a_strobe_width_exact: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(strobe_on) |-> chk_strobe_cnt_ff == chk_exp_w)
    else $error("strobe width does not match stretch code");

  a_strobe_outside_margins: assert property (@(posedge clk_sys) disable iff (reset)
    (state_ff == PH_SETUP || state_ff == PH_HOLD || state_ff == PH_ALE) |-> rd_n_ff && wr_n_ff)
    else $error("strobe active in setup, hold or latch phase");

  a_ale_large_miss: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && take && miss_eff && stretch_sel_ff[2] && page_bus_enable &&
     page_cycle_select == `PMDS_PAGES_4CLK) |=> ale_ff [*8] ##1 !ale_ff)
    else $error("latch strobe not widened by a stretch cycle");

  a_hit_shorter_miss: assert property (@(posedge clk_sys) disable iff (reset)
    live_hit_total < live_miss_total)
    else $error("page hit cycle not shorter than miss");

  a_large_setup_hold: assert property (@(posedge clk_sys) disable iff (reset)
    stretch_sel_ff[2] |-> (live_setup == 6'h09 && live_hold == 6'h05))
    else $error("large stretch setup or hold wrong");

  a_nonpage_always_ale: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && take && (!page_bus_enable || page_cycle_select == `PMDS_PAGES_ALT)) |=> ale_ff ##1 ale_ff)
    else $error("fixed four-clock bus access without address latch");

  a_zero_stretch_short: assert property (@(posedge clk_sys) disable iff (reset)
    (adv && follow_ph == PH_IDLE && chk_code_ff == 3'h0) |-> chk_acc_cnt_ff <= `PMDS_ZERO_STRETCH_MAX)
    else $error("unstretched access exceeds two basic cycles");

  a_qosc_slow_scale: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && clock_divide_select == `PMDS_CD_SLOW) |=> qosc_ff == 17'($past(live_strobe)) * 17'h0_1000)
    else $error("oscillator width not scaled by 1024 oscillator clocks");

  a_done_after_strobe: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(strobe_on) |-> ##[0:12] done_ff)
    else $error("access did not finish after strobe");

  a_miss_large_extra: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(ale_ff) && chk_large_ff && chk_miss_ff |-> $past(ale_len_ff) >= 6'h05)
    else $error("latch strobe length too short on large miss");
endmodule

// [include/pmds_defs.svh]
// Constants of the page-mode data stretch block
`ifndef PMDS_DEFS_SVH
`define PMDS_DEFS_SVH

// Stretch machine cycle and group shaping
`define PMDS_STRETCH_CLKS 6'h04
`define PMDS_LARGE_OFFSET 4'h3
`define PMDS_SMALL_SETUP 6'h01
`define PMDS_SMALL_HOLD 6'h01
`define PMDS_LARGE_SETUP 6'h09
`define PMDS_LARGE_HOLD 6'h05
`define PMDS_LARGE_ALE 6'h04
`define PMDS_STRETCH_RST 3'h1

// Page cycle select codes
`define PMDS_PAGES_1CLK 2'h0
`define PMDS_PAGES_2CLK 2'h1
`define PMDS_PAGES_4CLK 2'h2
`define PMDS_PAGES_ALT 2'h3

// Basic cycle lengths in system clocks
`define PMDS_HIT_1 6'h01
`define PMDS_HIT_2 6'h02
`define PMDS_HIT_4 6'h04
`define PMDS_FOUR_ALE 6'h02
`define PMDS_STROBE_NARROW 6'h01
`define PMDS_STROBE_WIDE 6'h02

// Clock setting {multiplier, divide} and quarter-oscillator scale
`define PMDS_CLK_QUARTER 3'h4
`define PMDS_CLK_HALF 3'h0
`define PMDS_CD_SLOW 2'h3
`define PMDS_SCALE_QUARTER 13'h0001
`define PMDS_SCALE_HALF 13'h0002
`define PMDS_SCALE_DIV1 13'h0004
`define PMDS_SCALE_SLOW 13'h1000

// Longest unstretched access in system clocks
`define PMDS_ZERO_STRETCH_MAX 7'h08

`endif

// [include/pmds_pkg.sv]
// Types shared by the page-mode data stretch block
package pmds_pkg;
  typedef logic [5:0] pmds_len_t;
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ALE,
    PH_SETUP,
    PH_STROBE,
    PH_HOLD,
    PH_TAIL
  } pmds_phase_e;
endpackage

// [rtl/pmds_phase_cnt.sv]
// Phase length down counter for the data stretch sequencer
`include "pmds_defs.svh"
module pmds_phase_cnt import pmds_pkg::*; #(
  parameter int LEN_W = 6
) (
  // Clock and control
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // Load and status
  input wire logic load,
  input wire logic [LEN_W-1:0] load_val,
  output logic last
);
  logic [LEN_W-1:0] cnt_ff;

  if (LEN_W < 6) begin : g_chk
    $error("pmds_phase_cnt: LEN_W too small for 28-clock strobe");
  end

  assign last = (cnt_ff == LEN_W'(1));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (load) begin
        cnt_ff <= load_val;
      end else if (cnt_ff != '0) begin
        cnt_ff <= cnt_ff - LEN_W'(1);
      end
    end
  end
endmodule

// [rtl/pmds_timing.sv]
// Phase lengths of one external data access for a stretch and page setting
`include "pmds_defs.svh"
module pmds_timing import pmds_pkg::*; (
  // Settings
  input wire logic [2:0] stretch_code,
  input wire logic [1:0] page_cycle_select,
  input wire logic page_bus_enable,
  input wire logic miss,
  // Stretch cycle count and lengths in system clocks
  output logic [3:0] stretch_cycles,
  output pmds_len_t ale_len,
  output pmds_len_t setup_len,
  output pmds_len_t strobe_len,
  output pmds_len_t hold_len,
  output pmds_len_t tail_len,
  output logic [6:0] hit_total,
  output logic [6:0] miss_total
);
  logic large_grp;
  logic small_grp;
  logic four_mode;
  pmds_len_t hit_len;
  pmds_len_t strobe_base;
  pmds_len_t ale_base;
  pmds_len_t ale_extra;
  pmds_len_t stretch_clks;

  // Charge strength keywords cannot name these group flags
  assign large_grp = stretch_code[2];
  assign small_grp = !stretch_code[2] && (stretch_code != 3'h0);
  // Codes 4..7 jump to 7..10 cycles
  assign stretch_cycles = {1'b0, stretch_code} + (large_grp ? `PMDS_LARGE_OFFSET : 4'h0);
  assign stretch_clks = 6'(stretch_cycles * `PMDS_STRETCH_CLKS);
  // Nonpage and alternate bus both use the fixed four-clock data cycle
  assign four_mode = !page_bus_enable || (page_cycle_select == `PMDS_PAGES_ALT);
  assign hit_len = four_mode ? `PMDS_HIT_4 :
                   (page_cycle_select == `PMDS_PAGES_1CLK) ? `PMDS_HIT_1 :
                   (page_cycle_select == `PMDS_PAGES_2CLK) ? `PMDS_HIT_2 : `PMDS_HIT_4;
  assign strobe_base = (four_mode || page_cycle_select == `PMDS_PAGES_4CLK) ?
                       `PMDS_STROBE_WIDE : `PMDS_STROBE_NARROW;
  assign ale_base = four_mode ? `PMDS_FOUR_ALE : hit_len;
  assign ale_extra = large_grp ? `PMDS_LARGE_ALE : 6'h00;
  // First stretch gives one clock setup/float and one clock hold
  assign setup_len = large_grp ? `PMDS_LARGE_SETUP : small_grp ? `PMDS_SMALL_SETUP : 6'h00;
  assign hold_len = large_grp ? `PMDS_LARGE_HOLD : small_grp ? `PMDS_SMALL_HOLD : 6'h00;
  assign strobe_len = strobe_base + stretch_clks - setup_len - hold_len;
  assign tail_len = four_mode ? 6'h00 : hit_len - strobe_base;
  assign ale_len = miss ? (ale_base + ale_extra) : 6'h00;
  assign hit_total = 7'(setup_len + strobe_len + hold_len + tail_len);
  assign miss_total = 7'(hit_total + ale_base + ale_extra);
endmodule

// [dv/pmds_ext_mem.sv]
// External memory model that needs a minimum strobe width to finish an access
module pmds_ext_mem (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Bus strobes from the block
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  // Part speed and outcome
  input wire logic [5:0] access_clks,
  output logic done_ok_ff,
  output logic clash_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt_ff;
  wire logic strobe_on;
  wire logic [5:0] nxt_cnt;
  assign strobe_on = !rd_n || !wr_n;
  assign nxt_cnt = strobe_on ? cnt_ff + 6'h01 : 6'h00;
  ////////////////////////////////////////////////////////////
  // Slow parts only finish when the strobe lasts at least their access time
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_ff <= 6'h00;
      done_ok_ff <= 1'b0;
      clash_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      if (strobe_on) begin
        done_ok_ff <= nxt_cnt >= access_clks;
      end
      if ((!rd_n && !wr_n) || (ale && strobe_on)) begin
        clash_ff <= 1'b1;
      end
    end
  end
endmodule

// [dv/tb.sv]
// Self-checking bench for the page-mode data stretch sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic stretch_wr = 1'b0;
  logic [2:0] stretch_wdata = 3'h0;
  logic page_bus_enable = 1'b1;
  logic [1:0] page_cycle_select = 2'h1;
  logic [1:0] clock_divide_select = 2'h2;
  logic clock_multiplier_select = 1'b0;
  logic access_req = 1'b0;
  logic access_write = 1'b0;
  logic page_hit = 1'b0;
  logic [5:0] access_clks = 6'h01;
  logic [2:0] stretch_select;
  logic [3:0] stretch_cycles;
  logic [16:0] strobe_width_qosc;
  logic busy, access_done, ale, rd_n, wr_n, done_ok, clash;
  int num_errors = 0;
  int checked = 0;

  always #5 clk_sys = ~clk_sys;

  pmds_data_stretch pmds_data_stretch_i (.clk_sys(clk_sys), .reset(reset), .ce(ce),
    .stretch_wr(stretch_wr), .stretch_wdata(stretch_wdata), .page_bus_enable(page_bus_enable),
    .page_cycle_select(page_cycle_select), .clock_divide_select(clock_divide_select),
    .clock_multiplier_select(clock_multiplier_select), .access_req(access_req),
    .access_write(access_write), .page_hit(page_hit), .stretch_select(stretch_select),
    .stretch_cycles(stretch_cycles), .strobe_width_qosc(strobe_width_qosc), .busy(busy),
    .access_done(access_done), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
  pmds_ext_mem pmds_ext_mem_i (.clk_sys(clk_sys), .reset(reset), .ale(ale), .rd_n(rd_n),
    .wr_n(wr_n), .access_clks(access_clks), .done_ok_ff(done_ok), .clash_ff(clash));

  ////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      num_errors++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask

  function automatic int cyc_of(input logic [2:0] c);
    return c[2] ? int'(c) + 3 : int'(c);
  endfunction
  function automatic int setup_of(input logic [2:0] c);
    return c == 3'h0 ? 0 : (c[2] ? 9 : 1);
  endfunction
  function automatic int hold_of(input logic [2:0] c);
    return c == 3'h0 ? 0 : (c[2] ? 5 : 1);
  endfunction
  function automatic int width_of(input logic [2:0] c, input logic [1:0] pg, input logic four);
    return ((four || pg == 2'h2) ? 2 : 1) + 4 * cyc_of(c) - setup_of(c) - hold_of(c);
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One access; counts strobe, latch and completion samples against the figures
  task automatic access(input logic [2:0] code, input logic [1:0] pg, input logic en, wr, hit,
                        output int total);
    int hl, al, sb, tl, n, n_ale, n_sb, first;
    logic four;
    four = !en || pg == 2'h3;
    hl = four ? 4 : (pg == 2'h0 ? 1 : (pg == 2'h1 ? 2 : 4));
    sb = width_of(code, pg, four);
    al = (!hit || pg == 2'h0 || four) ? (four ? 2 : hl) + (code[2] ? 4 : 0) : 0;
    tl = four ? 0 : hl - ((pg == 2'h2) ? 2 : 1);
    total = al + setup_of(code) + sb + hold_of(code) + tl + 1;
    stretch_wdata = code;
    stretch_wr = 1'b1;
    page_cycle_select = pg;
    page_bus_enable = en;
    @(negedge clk_sys);
    stretch_wr = 1'b0;
    access_req = 1'b1;
    access_write = wr;
    page_hit = hit;
    @(negedge clk_sys);
    access_req = 1'b0;
    n = 1;
    n_ale = 0;
    n_sb = 0;
    first = 0;
    while (access_done !== 1'b1 && n < 200) begin
      if (ale === 1'b1) n_ale++;
      if ((wr ? wr_n : rd_n) === 1'b0) begin
        n_sb++;
        if (first == 0) first = n;
      end
      chk((wr ? rd_n : wr_n) === 1'b1, "wrong strobe active");
      n++;
      @(negedge clk_sys);
    end
    chk(n_ale == al, "latch strobe width");
    chk(n_sb == sb, "data strobe width");
    chk(first == al + setup_of(code) + 1, "setup before strobe");
    chk(n == total && busy === 1'b0, "access length");
    @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values();
    chk(stretch_select === 3'h1 && stretch_cycles === 4'h1, "stretch after reset");
    chk(busy === 1'b0 && ale === 1'b0 && rd_n === 1'b1 && wr_n === 1'b1, "idle bus");
  endtask

  task automatic t_code_table();
    for (int c = 0; c < 8; c++) begin
      stretch_wdata = 3'(c);
      stretch_wr = 1'b1;
      page_cycle_select = 2'h0;
      @(negedge clk_sys);
      stretch_wr = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(stretch_select === 3'(c), "stretch select");
      chk(stretch_cycles === 4'(cyc_of(3'(c))), "stretch cycles");
      chk(strobe_width_qosc === 17'(4 * width_of(3'(c), 2'h0, 1'b0)), "narrow width");
      page_cycle_select = 2'h2;
      repeat (2) @(negedge clk_sys);
      chk(strobe_width_qosc === 17'(4 * width_of(3'(c), 2'h2, 1'b0)), "wide width");
    end
  endtask

  task automatic t_clock_scale();
    logic [2:0] sets [6] = '{3'h4, 3'h0, 3'h2, 3'h6, 3'h3, 3'h7};
    int scale [6] = '{1, 2, 4, 4, 4096, 4096};
    for (int i = 0; i < 6; i++) begin
      {clock_multiplier_select, clock_divide_select} = sets[i];
      repeat (2) @(negedge clk_sys);
      chk(strobe_width_qosc === 17'(scale[i] * width_of(3'h7, 2'h2, 1'b0)), "clock scaling");
    end
    {clock_multiplier_select, clock_divide_select} = 3'h2;
  endtask

  task automatic t_miss_sweep();
    int t;
    for (int c = 0; c < 8; c++) begin
      access(3'(c), 2'h1, 1'b1, c[0], 1'b0, t);
    end
    access(3'h2, 2'h0, 1'b1, 1'b0, 1'b1, t);
  endtask

  task automatic t_hit_shorter();
    int th, tm;
    for (int c = 0; c < 8; c++) begin
      access(3'(c), 2'h2, 1'b1, 1'b1, 1'b1, th);
      access(3'(c), 2'h2, 1'b1, 1'b1, 1'b0, tm);
      chk(th < tm, "hit not shorter than miss");
    end
  endtask

  task automatic t_four_clock_bus();
    int ta, tn;
    for (int i = 0; i < 3; i++) begin
      access(i ? 3'h4 : 3'h1, 2'h3, 1'b1, 1'b0, 1'b1, ta);
      access(i ? 3'h4 : 3'h1, 2'h1, 1'b0, 1'b0, 1'b1, tn);
      chk(ta == tn, "alternate bus differs from nonpage");
    end
  endtask

  task automatic t_slow_part();
    int t;
    access_clks = 6'h14;
    access(3'h5, 2'h1, 1'b1, 1'b0, 1'b0, t);
    chk(done_ok === 1'b0, "slow part finished early");
    access(3'h6, 2'h1, 1'b1, 1'b1, 1'b0, t);
    chk(done_ok === 1'b1, "slow part not finished");
    chk(clash === 1'b0, "strobes overlapped");
  endtask

  // Large-code miss read with the enable low for five clocks in the latch phase
  task automatic t_ce_freeze();
    int n;
    stretch_wdata = 3'h4;
    stretch_wr = 1'b1;
    page_cycle_select = 2'h1;
    page_bus_enable = 1'b1;
    @(negedge clk_sys);
    stretch_wr = 1'b0;
    access_req = 1'b1;
    access_write = 1'b0;
    page_hit = 1'b0;
    @(negedge clk_sys);
    access_req = 1'b0;
    ce = 1'b0;
    for (n = 1; n < 6; n++) begin
      @(negedge clk_sys);
      chk(ale === 1'b1 && busy === 1'b1 && rd_n === 1'b1 && access_done === 1'b0, "moved with enable low");
    end
    ce = 1'b1;
    while (access_done !== 1'b1 && n < 200) begin
      n++;
      @(negedge clk_sys);
    end
    // Latch 6, setup 9, strobe 15, hold 5, tail 1, done 1, frozen 5
    chk(n == 42, "access length with enable gap");
    @(negedge clk_sys);
  endtask

  // Reset in the middle of a write strobe
  task automatic t_mid_reset();
    stretch_wdata = 3'h3;
    stretch_wr = 1'b1;
    @(negedge clk_sys);
    stretch_wr = 1'b0;
    access_req = 1'b1;
    access_write = 1'b1;
    page_hit = 1'b1;
    @(negedge clk_sys);
    access_req = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk(wr_n === 1'b0, "write strobe before second reset");
    reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    chk(stretch_select === 3'h1 && stretch_cycles === 4'h1, "stretch after second reset");
    chk(busy === 1'b0 && wr_n === 1'b1 && access_done === 1'b0, "bus after second reset");
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    num_errors++;
    final_report();
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    @(negedge clk_sys);
    t_reset_values();
    t_code_table();
    t_clock_scale();
    t_miss_sweep();
    t_hit_shorter();
    t_four_clock_bus();
    t_slow_part();
    t_ce_freeze();
    t_mid_reset();
    final_report();
  end
endmodule
